//--- logic/ssr_consts.svh
// ssr_consts.svh: timing counts and reset values for the rectifier sequencer
// assumes a 25 MHz clock; included by bare name from logic/
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
`define SSR_CLK_MHZ          25
`define SSR_OFF_DELAY_NS     110
// count truncates to 2; the registered rectifier gate adds one cycle after done, so the gap is 3 cycles, 120 ns
`define SSR_OFF_DELAY_CYC    ((`SSR_OFF_DELAY_NS * `SSR_CLK_MHZ) / 1000)
`define SSR_DLY_W            8
`define SSR_GATE_RST         1'b0
`endif

//--- logic/ssr_pkg.sv
// ssr_pkg.sv: types shared by the rectifier sequencer and its delay timer
// assumes nothing of its surroundings
package ssr_pkg;
   typedef enum logic [2:0] {
      SSR_OFF      = 3'b000,
      SSR_SOFT     = 3'b001,
      SSR_DEAD     = 3'b010,
      SSR_FWD      = 3'b011,
      SSR_GAP      = 3'b100,
      SSR_WAIT_LOW = 3'b101,
      SSR_RECT     = 3'b110,
      SSR_HICCUP   = 3'b111
   } ssr_state_t;
endpackage

//--- logic/ssr_delay_if.sv
// ssr_delay_if.sv: start/done pair between sequencer and fixed delay timer
// assumes one clock domain shared by both ends
interface ssr_delay_if;
   logic start;
   logic done;
   modport seq (output start, input done);
   modport tmr (input start, output done);
endinterface

//--- logic/ssr_delay_timer.sv
// ssr_delay_timer.sv: one-shot counter giving the fixed turn-off to rectifier delay
// assumes start is a one-cycle pulse from the sequencer
`include "ssr_consts.svh"
module ssr_delay_timer import ssr_pkg::*; #(
   parameter int                W     = `SSR_DLY_W,
   parameter logic [W-1:0]      COUNT = W'(`SSR_OFF_DELAY_CYC)
) (
   input  wire logic clock,
   input  wire logic rst_b,
   ssr_delay_if.tmr  dly
);
   logic [W-1:0] count;
   logic         busy;

   // load on start, count down, pulse done at zero
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count    <= '0;
         busy     <= 1'b0;
         dly.done <= 1'b0;
      end else begin
         dly.done <= 1'b0;
         if (dly.start) begin
            count <= (COUNT > 1) ? W'(COUNT - 1) : '0;
            busy  <= 1'b1;
         end else if (busy) begin
            if (count == '0) begin
               busy     <= 1'b0;
               dly.done <= 1'b1;
            end else begin
               count <= count - 1'b1;
            end
         end
      end
   end
endmodule // ssr_delay_timer

//--- logic/ssr_sequencer.sv
// ssr_sequencer.sv: sequencing and gate logic of a secondary-side synchronous
// rectifier and post-regulator; analog thresholds arrive as comparator bits.
// assumes all comparator inputs are synchronous to clock (25 MHz).
// How it works
// R01: run only with supply good and enable above threshold
// R02: deactivated: gates low, amp tracks softstart; softstart pulled low only while supply not good
// R03: released: soft-start current source switched on
// R04: error amp output tracks soft-start node
// R05: soft start done at 3.3V flag
// R06: transformer waveform is the only timebase
// R07: two hysteretic crossover comparators feed logic
// R08: low comparator rise drops rectifier gate immediately
// R09: same instant enable ramp discharge sink
// R10: forward on after ramp valley and high rise
// R11: trailing-edge, complementary forward and rectifier gates
// R12: ramp peak terminates forward pulse
// R13: PWM end waits fixed delay before rectifier
// R14: high comparator fall ends forward pulse
// R15: then rectifier on at low comparator fall
// R16: peak current limit, hiccup on short circuit
// R17: current limit ends forward, rectifier stays on
// R18: output below half nominal shuts both gates; not checked in SOFT, where the rectifier gate can stay on
// R19: discharge softstart to 0.8V, then restart
// R20: comparator bits inputs, delay from configurable timer
// R21: sink follows forward gate, never with rectifier
`include "ssr_consts.svh"
module ssr_sequencer import ssr_pkg::*; #(
   parameter int           DLY_W     = `SSR_DLY_W,
   parameter logic [DLY_W-1:0] OFF_DLY = DLY_W'(`SSR_OFF_DELAY_CYC)
) (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic supply_good,          // supply above lockout threshold
   input  wire logic enable_above,         // softstart node above enable threshold
   input  wire logic softstart_done,       // softstart node reached full level
   input  wire logic softstart_low,        // softstart node at or below restart level
   input  wire logic xover_low,            // low hysteretic crossover comparator
   input  wire logic xover_high,           // high hysteretic crossover comparator
   input  wire logic ramp_valley,          // ramp discharged to lower threshold
   input  wire logic ramp_peak,            // ramp at clamped peak
   input  wire logic pwm_trip,             // ramp above error amp output
   input  wire logic current_limit,        // current amp output at limit
   input  wire logic output_undervolt,     // sensed output below half nominal
   output logic      forward_gate_drive,
   output logic      drive_transformer_sink,
   output logic      low_side_gate_drive,
   output logic      ramp_discharge,
   output logic      softstart_charge,
   output logic      softstart_discharge,
   output logic      softstart_pull_low,
   output logic      error_amp_track,
   output logic      fault_flag
);
   ssr_state_t state;
   ssr_state_t next_state;
   logic       xlow_q;
   logic       xhigh_q;
   logic       active;
   logic       fwd_stop;
   logic       high_fall;
   logic       low_fall;
   logic       low_rise;
   ssr_delay_if dly ();

   ssr_delay_timer #(.W(DLY_W), .COUNT(OFF_DLY)) u_delay ( // [R20]
      .clock (clock),
      .rst_b (rst_b),
      .dly   (dly)
   );

   // edge history of the crossover comparators; the waveform is the timebase
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         xlow_q  <= 1'b0;
         xhigh_q <= 1'b0;
      end else begin
         xlow_q  <= xover_low;   // [R07]
         xhigh_q <= xover_high;  // [R06]
      end
   end

   assign active    = supply_good & enable_above;            // [R01]
   assign low_rise  = xover_low & ~xlow_q;
   assign low_fall  = ~xover_low & xlow_q;
   assign high_fall = ~xover_high & xhigh_q;
   // regulated termination: PWM, ramp peak or current limit
   assign fwd_stop  = pwm_trip | ramp_peak | current_limit;  // [R12] [R17]
   assign dly.start = (state == SSR_FWD) & ~high_fall & fwd_stop & ~output_undervolt;

   // next-state decision; hiccup and deactivation take priority
   always_comb begin
      next_state = state;
      if (!active) begin
         next_state = SSR_OFF;                               // [R01]
      end else if (output_undervolt && state != SSR_OFF && state != SSR_SOFT
                   && state != SSR_HICCUP) begin
         next_state = SSR_HICCUP;                            // [R18] [R16]
      end else begin
         case (state)
            SSR_OFF:      next_state = SSR_SOFT;
            SSR_SOFT:     if (softstart_done) next_state = SSR_RECT; // [R05]
            SSR_RECT:     if (low_rise) next_state = SSR_DEAD;       // [R08]
            SSR_DEAD:     if (ramp_valley && xover_high) next_state = SSR_FWD; // [R10]
            SSR_FWD: begin
               if (high_fall) next_state = SSR_WAIT_LOW;       // [R14]
               else if (fwd_stop) next_state = SSR_GAP;        // [R11]
            end
            // no early exit: the rectifier must never beat the fixed gap
            SSR_GAP:      if (dly.done) next_state = SSR_RECT;         // [R13]
            SSR_WAIT_LOW: if (low_fall || !xover_low) next_state = SSR_RECT; // [R15]
            SSR_HICCUP:   if (softstart_low) next_state = SSR_SOFT;          // [R19]
            default:      next_state = SSR_OFF;
         endcase
      end
   end

   // state register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) state <= SSR_OFF;
      else        state <= next_state;
   end

   // gate drives decoded from next state so outputs stay registered
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         forward_gate_drive     <= `SSR_GATE_RST;
         drive_transformer_sink <= `SSR_GATE_RST;
         low_side_gate_drive    <= `SSR_GATE_RST;
         ramp_discharge         <= 1'b0;
      end else begin
         forward_gate_drive     <= (next_state == SSR_FWD);  // [R11]
         drive_transformer_sink <= (next_state == SSR_FWD);  // [R21]
         // rectifier in RECT, or in SOFT while the low crossover is low; never in FWD, so it never overlaps the forward pulse
         low_side_gate_drive    <= (next_state == SSR_RECT) | (next_state == SSR_SOFT && !xover_low); // [R02]
         ramp_discharge         <= (next_state == SSR_DEAD) & ~ramp_valley; // [R09]
      end
   end

   // soft-start and error amp control; analog current values live outside
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         softstart_charge    <= 1'b0;
         softstart_discharge <= 1'b0;
         softstart_pull_low  <= 1'b1;
         error_amp_track     <= 1'b0;
         fault_flag          <= 1'b0;
      end else begin
         softstart_pull_low  <= ~supply_good;                          // [R02]
         // source runs below the enable level too, else the node could never climb past it
         softstart_charge    <= supply_good & (next_state != SSR_HICCUP);  // [R03]
         softstart_discharge <= (next_state == SSR_HICCUP);            // [R19]
         error_amp_track     <= (next_state == SSR_SOFT) | ~active;    // [R04]
         fault_flag          <= (next_state == SSR_HICCUP);            // [R18]
      end
   end

   a_gates_exclusive: assert property (@(posedge clock) disable iff (!rst_b) // [R21]
      !(forward_gate_drive && low_side_gate_drive))
      else $error("forward and rectifier gates overlap");
   a_sink_follows: assert property (@(posedge clock) disable iff (!rst_b) // [R21]
      drive_transformer_sink == forward_gate_drive)
      else $error("sink not synchronous to forward gate");
   a_off_gates_low: assert property (@(posedge clock) disable iff (!rst_b) // [R02]
      !active |=> !forward_gate_drive && !drive_transformer_sink)
      else $error("gate high while deactivated");
   a_low_rise_cut: assert property (@(posedge clock) disable iff (!rst_b) // [R08]
      (state == SSR_RECT && low_rise && active && !output_undervolt) |=> !low_side_gate_drive)
      else $error("rectifier not cut on crossover rise");
   a_fwd_needs_both: assert property (@(posedge clock) disable iff (!rst_b) // [R10]
      $rose(forward_gate_drive) |-> $past(ramp_valley) && $past(xover_high))
      else $error("forward on without valley and high crossover");
   a_trail_stop: assert property (@(posedge clock) disable iff (!rst_b) // [R12]
      (state == SSR_FWD && fwd_stop) |=> !forward_gate_drive)
      else $error("forward pulse not ended");
   a_fixed_delay: assert property (@(posedge clock) disable iff (!rst_b) // [R13]
      (dly.start && active) |=> !low_side_gate_drive)
      else $error("rectifier on before fixed delay");
   a_delay_done: assert property (@(posedge clock) disable iff (!rst_b) // [R13]
      dly.start |-> ##[1:4] dly.done)
      else $error("delay timer never finished");
   a_fall_cut: assert property (@(posedge clock) disable iff (!rst_b) // [R14]
      (state == SSR_FWD && high_fall) |=> !forward_gate_drive ##0 !low_side_gate_drive)
      else $error("high crossover fall did not end forward");
   a_hiccup_shut: assert property (@(posedge clock) disable iff (!rst_b) // [R18]
      (next_state == SSR_HICCUP) |=> fault_flag && !low_side_gate_drive && !forward_gate_drive)
      else $error("undervoltage did not shut both gates");
   a_softstart_end: assert property (@(posedge clock) disable iff (!rst_b) // [R05]
      (state == SSR_SOFT && softstart_done && active && !output_undervolt) |=> state == SSR_RECT)
      else $error("soft start did not complete");

   c_pwm_cycle:  cover property (@(posedge clock) disable iff (!rst_b) state == SSR_GAP ##[1:4] state == SSR_RECT);
   c_fall_cycle: cover property (@(posedge clock) disable iff (!rst_b) state == SSR_WAIT_LOW);
   c_hiccup:     cover property (@(posedge clock) disable iff (!rst_b) state == SSR_HICCUP ##1 state == SSR_SOFT);
   c_forward:    cover property (@(posedge clock) disable iff (!rst_b) $rose(forward_gate_drive));
endmodule // ssr_sequencer

//--- bench/ssr_winding_model.sv
// ssr_winding_model.sv: secondary winding crossings and timing ramp seen by the sequencer
// assumes level in quarter-volt steps, driven by the bench just after each clock edge
module ssr_winding_model (
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic [4:0] level,
   input  wire logic       ramp_discharge,
   output logic            xover_low,
   output logic            xover_high,
   output logic            ramp_valley,
   output logic            ramp_peak
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       low_q;
   logic       high_q;
   logic [3:0] ramp;
   // winding is the only timebase; hysteresis 0.75/0.25 and 3.5/2.5
   assign xover_low   = (level >= 5'h03) || (low_q && level > 5'h01);
   assign xover_high  = (level >= 5'h0E) || (high_q && level > 5'h0A);
   assign ramp_valley = (ramp <= 4'h4); // 1V of a 3V scale
   assign ramp_peak   = (ramp == 4'hC); // clamped peak
   // ramp rests at its peak before the rise, sink pulls it fast, charge is slow
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         low_q  <= 1'b0;
         high_q <= 1'b0;
         ramp   <= 4'hC;
      end else begin
         low_q  <= xover_low;
         high_q <= xover_high;
         if (ramp_discharge)
            ramp <= (ramp > 4'h8) ? ramp - 4'h4 : 4'h4;
         else if (ramp < 4'hC)
            ramp <= ramp + 4'h1;
      end
   end
endmodule // ssr_winding_model

//--- bench/ssr_sequencer_bench.sv
// ssr_sequencer_bench.sv: self-checking bench for the rectifier sequencer
// assumes the winding model stands for transformer and ramp; 25 MHz clock
module ssr_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock, rst_b, supply_good, enable_above, softstart_done, softstart_low;
   logic       xover_low, xover_high, ramp_valley, ramp_peak, pwm_trip, current_limit, output_undervolt;
   logic       forward_gate_drive, drive_transformer_sink, low_side_gate_drive, ramp_discharge;
   logic       softstart_charge, softstart_discharge, softstart_pull_low, error_amp_track, fault_flag;
   logic [4:0] level;
   int         n_mismatch = 0;
   int         tests_run = 0;
   ssr_sequencer #(.OFF_DLY(8'h02)) dut (.clock, .rst_b, .supply_good, .enable_above, .softstart_done,
      .softstart_low, .xover_low, .xover_high, .ramp_valley, .ramp_peak, .pwm_trip, .current_limit,
      .output_undervolt, .forward_gate_drive, .drive_transformer_sink, .low_side_gate_drive, .ramp_discharge,
      .softstart_charge, .softstart_discharge, .softstart_pull_low, .error_amp_track, .fault_flag);
   ssr_winding_model wind (.clock, .rst_b, .level, .ramp_discharge, .xover_low, .xover_high,
      .ramp_valley, .ramp_peak);
   // 40 ns period
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // inputs always move 1 ns after the edge, outputs are settled there
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic check(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // winding rise: rectifier off at once, forward waits for valley and high crossing
   task automatic rise();
      level = 5'h00;
      step(8);
      level = 5'h03;
      step(1);
      check("low_side", 1'b0, low_side_gate_drive);
      check("ramp_discharge", 1'b1, ramp_discharge);
      step(3);
      check("forward early", 1'b0, forward_gate_drive);
      level = 5'h0F;
      step(1);
      check("forward", 1'b1, forward_gate_drive);
      check("sink", 1'b1, drive_transformer_sink);
      check("low_side fwd", 1'b0, low_side_gate_drive);
   endtask
   task automatic t_enable();
      step(2);
      check("pull low", 1'b1, softstart_pull_low);
      check("fwd off", 1'b0, forward_gate_drive);
      check("rect off", 1'b0, low_side_gate_drive);
      supply_good = 1'b1; // lockout clears, enable still held low
      step(1);
      check("pull released", 1'b0, softstart_pull_low);
      check("charge early", 1'b1, softstart_charge);
      check("fwd no enable", 1'b0, forward_gate_drive);
      enable_above = 1'b1;
      step(2);
      check("charge", 1'b1, softstart_charge);
      check("track", 1'b1, error_amp_track);
      check("rect soft", 1'b1, low_side_gate_drive);
      softstart_done = 1'b1;
      step(2);
      check("track end", 1'b0, error_amp_track);
      rise();
      supply_good = 1'b0; // lockout in mid-pulse
      step(1);
      check("lockout fwd", 1'b0, forward_gate_drive);
      check("lockout sink", 1'b0, drive_transformer_sink);
      check("lockout pull", 1'b1, softstart_pull_low);
      supply_good = 1'b1;
      step(1);
      check("soft rect off", 1'b0, low_side_gate_drive);
      step(2);
      $display("t_enable done");
   endtask
   // pulse ended by pwm comparator, current limit, then ramp peak; all take the fixed gap
   task automatic t_stop();
      int k;
      int i;
      for (k = 0; k < 3; k++) begin
         rise();
         step(2);
         pwm_trip = (k == 0);
         current_limit = (k == 1);
         for (i = 0; i < 12 && forward_gate_drive === 1'b1; i++)
            step(1);
         check("stop cause", 1'b1, i == ((k == 2) ? 6 : 1));
         check("sink off", 1'b0, drive_transformer_sink);
         check("gap", 1'b0, low_side_gate_drive);
         pwm_trip = 1'b0;
         current_limit = 1'b0;
         step(1);
         check("gap", 1'b0, low_side_gate_drive);
         for (i = 0; i < 4 && low_side_gate_drive !== 1'b1; i++)
            step(1);
         check("rect after gap", 1'b1, low_side_gate_drive);
         check("gap length", 1'b1, i == 2);
      end
      $display("t_stop done");
   endtask
   // falling winding ends forward at the high crossing, rectifier waits for the low one
   task automatic t_fall();
      rise();
      level = 5'h08;
      step(1);
      check("fwd at fall", 1'b0, forward_gate_drive);
      step(3);
      check("rect held", 1'b0, low_side_gate_drive);
      level = 5'h00;
      step(1);
      check("rect at low", 1'b1, low_side_gate_drive);
      $display("t_fall done");
   endtask
   task automatic t_hiccup();
      rise();
      output_undervolt = 1'b1;
      softstart_done = 1'b0;
      step(1);
      check("fault", 1'b1, fault_flag);
      check("fwd fault", 1'b0, forward_gate_drive);
      check("rect fault", 1'b0, low_side_gate_drive);
      check("ss discharge", 1'b1, softstart_discharge);
      output_undervolt = 1'b0;
      step(2);
      check("still hiccup", 1'b1, fault_flag);
      softstart_low = 1'b1;
      step(2);
      check("restart", 1'b1, softstart_charge);
      check("fault clear", 1'b0, fault_flag);
      softstart_low = 1'b0;
      softstart_done = 1'b1;
      step(2);
      $display("t_hiccup done");
   endtask
   // supply and enable both low at release, so the block starts locked out
   initial begin
      {rst_b, enable_above, softstart_done, softstart_low, pwm_trip, current_limit, output_undervolt} = '0;
      supply_good = 1'b0;
      level = 5'h00;
      step(2);
      rst_b = 1'b1;
      t_enable();
      t_stop();
      t_fall();
      t_hiccup();
      summarize();
   end
   // the tests need about 130 cycles; this cuts off a hang at 2500 cycles
   initial begin
      #100000;
      n_mismatch++;
      summarize();
   end
endmodule // ssr_sequencer_bench
